// ==== common/blc_pkg.sv ====
package blc_pkg;

	localparam int unsigned NPATH = 8;
	localparam int unsigned PIX_W = 10;
	localparam int unsigned ACC_W = 17;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned LEN_W = 11;
	localparam int unsigned FIFO_DEPTH = 32;

	localparam logic [ADDR_W-1:0] ADDR_FILTER_CFG = 9'h080;
	localparam logic [ADDR_W-1:0] ADDR_CORR_CFG = 9'h081;
	localparam logic [ADDR_W-1:0] ADDR_SHORTFALL = 9'h088;
	localparam logic [ADDR_W-1:0] ADDR_ROW_CFG = 9'h0c5;

	localparam logic [DATA_W-1:0] RST_FILTER_CFG = 16'h0000;
	localparam logic [DATA_W-1:0] RST_CORR_CFG = 16'h0000;
	localparam logic [DATA_W-1:0] RST_ROW_CFG = 16'h0001;

	localparam int unsigned TGT_LSB = 0;
	localparam int unsigned TGT_W = 8;
	localparam int unsigned DEPTH_LSB = 8;
	localparam int unsigned DEPTH_W = 3;
	localparam int unsigned AUTO_BIT = 0;
	localparam int unsigned MOFS_LSB = 1;
	localparam int unsigned MOFS_W = 9;
	localparam int unsigned MSIGN_BIT = 10;
	localparam int unsigned ROWS_LSB = 0;
	localparam int unsigned ROWS_W = 8;
	localparam int unsigned SKIP_BIT = 8;

	localparam logic [LEN_W-1:0] GS_ROW_KERNELS = 11'h0a0;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_DARK  = 4'h2,
		ST_FIN   = 4'h4,
		ST_IMAGE = 4'h8
	} blc_state_e;

	typedef struct packed {
		logic [NPATH-1:0][PIX_W-1:0] pix;
		logic                        dark;
		logic                        blank;
	} blc_kernel_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              wr;
		logic              rd;
		logic [DATA_W-1:0] wdata;
	} blc_reg_req_s;

endpackage : blc_pkg

// ==== verification/blc_checker.sv ====
`timescale 1ns/10ps
module blc_checker (
	input wire logic                mclk,
	input wire logic                sys_rst,
	input wire logic [8:0]          reg_addr,
	input wire logic                reg_rd,
	input wire logic [15:0]         reg_rdata,
	input wire logic                frame_start,
	input wire logic                dark_row_active,
	input wire logic                out_valid,
	input wire logic                out_ready,
	input wire blc_pkg::blc_kernel_s out_kernel,
	input wire logic [7:0]          shortfall_flags
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	rst_vals_a: assert property ($past(sys_rst) |-> !dark_row_active && shortfall_flags == 8'h00)
		else $error("outputs not cleared by reset");
	flags_equal_a: assert property (shortfall_flags == 8'h00 || shortfall_flags == 8'hff)
		else $error("shortfall paths disagree");
	dark_cause_a: assert property ($rose(dark_row_active) |-> $past(frame_start))
		else $error("dark rows without frame start");
	dark_go_a: assert property (frame_start |=> dark_row_active)
		else $error("frame start gave no dark rows");
	flag_time_a: assert property ($changed(shortfall_flags) |-> !dark_row_active)
		else $error("flags moved during dark rows");
	blank_row_a: assert property (out_valid && out_kernel.blank |-> out_kernel.dark && out_kernel.pix == '0)
		else $error("blanked row not zero dark");
	rd_flags_a: assert property ($past(reg_rd) && $past(reg_addr) == 9'h088 |->
		reg_rdata[7:0] == $past(shortfall_flags))
		else $error("flag register differs from port");
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_kernel))
		else $error("output kernel lost while stalled");
	cover property (frame_start);
	cover property (out_valid && out_kernel.blank);
	cover property ($rose(shortfall_flags[0]));
endmodule : blc_checker
bind blc_top blc_checker u_blc_checker (.mclk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .frame_start,
	.dark_row_active, .out_valid, .out_ready, .out_kernel, .shortfall_flags);

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic                 mclk, sys_rst, reg_wr, reg_rd, frame_start, rolling_mode;
	logic                 in_valid, in_ready, out_valid, out_ready, dark_row_active;
	logic [8:0]           reg_addr;
	logic [15:0]          reg_wdata, reg_rdata;
	logic [10:0]          line_kernels;
	logic [7:0]           shortfall_flags;
	blc_pkg::blc_kernel_s in_kernel, out_kernel;
	blc_pkg::blc_kernel_s q[$];
	int                   fails, tests_run;
	blc_top u_blc_top (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .frame_start,
		.rolling_mode, .line_kernels, .dark_row_active, .in_valid, .in_ready, .in_kernel, .out_valid,
		.out_ready, .out_kernel, .shortfall_flags);
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) if (out_valid && out_ready) q.push_back(out_kernel);
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	task automatic step(inout int n);
		@(negedge mclk);
		n++;
		if (n > 999) begin
			fails++;
			close_out();
		end
	endtask : step
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge mclk);
		reg_wr = 0;
		// Let an edge pass so back-to-back writes give separate strobes
		@(negedge mclk);
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		reg_addr = a;
		reg_rd = 1;
		@(negedge mclk);
		reg_rd = 0;
		@(negedge mclk);
		chk("reg_rdata", reg_rdata, e);
	endtask : rd
	task automatic push(input int v, input int s);
		int n = 0;
		in_valid = 1;
		for (int c = 0; c < 8; c++) in_kernel.pix[c] = 10'(v + s * c);
		while (!in_ready) step(n);
		@(negedge mclk);
	endtask : push
	task automatic wait_q(input int k);
		int n = 0;
		while (q.size() < k) step(n);
	endtask : wait_q
	// With skip set, row 0 carries a far-off level so any leak into the average shows
	task automatic frame(input logic roll, input int len, input int rows, input logic skip, input int v);
		blc_pkg::blc_kernel_s k;
		logic b;
		frame_start = 1;
		rolling_mode = roll;
		// Global rows must ignore the window length, so give it a different value
		line_kernels = roll ? 11'(len) : 11'h05a;
		@(negedge mclk);
		frame_start = 0;
		chk("dark_row_active", 16'(dark_row_active), 16'h0001);
		for (int i = 0; i < rows * len; i++) push((i < len && skip) ? 500 : v, 1);
		in_valid = 0;
		chk("dark_row_active", 16'(dark_row_active), 16'h0000);
		wait_q(rows * len);
		for (int i = 0; i < rows * len; i++) begin
			k = q.pop_front();
			b = i < len && skip;
			chk("dark", 16'(k.dark), 16'h0001);
			chk("blank", 16'(k.blank), 16'(b));
			chk("raw", 16'(k.pix[7]), b ? 16'h0000 : 16'(v + 7));
		end
		repeat (3) @(negedge mclk);
	endtask : frame
	task automatic img(input int v, input int e, input int s);
		blc_pkg::blc_kernel_s k;
		push(v, 1);
		in_valid = 0;
		wait_q(1);
		k = q.pop_front();
		for (int c = 0; c < 8; c++) chk("pix", 16'(k.pix[c]), 16'(e + s * c));
		chk("img_dark", 16'(k.dark), 16'h0000);
	endtask : img
	task automatic s_regs();
		rd(9'h080, 16'h0000);
		rd(9'h081, 16'h0000);
		rd(9'h0c5, 16'h0001);
		rd(9'h1ff, 16'h0000);
		wr(9'h088, 16'hffff);
		rd(9'h088, 16'h0000);
		wr(9'h0c5, 16'h0102);
		rd(9'h0c5, 16'h0102);
	endtask : s_regs
	task automatic s_global();
		wr(9'h080, 16'h0705);
		wr(9'h081, 16'h0401);
		frame(0, 160, 2, 1, 20);
		chk("flags", 16'(shortfall_flags), 16'h0000);
		img(100, 85, 0);
		img(10, 0, 0);
	endtask : s_global
	// Rolling rows of 100 give too few samples; old black must survive
	task automatic s_roll();
		frame(1, 100, 2, 1, 40);
		chk("flags", 16'(shortfall_flags), 16'h00ff);
		rd(9'h088, 16'h00ff);
		img(100, 85, 0);
		wr(9'h0c5, 16'h0003);
		frame(1, 100, 3, 0, 40);
		chk("flags", 16'(shortfall_flags), 16'h0000);
		img(100, 65, 0);
	endtask : s_roll
	// Mid-run reset with a kernel parked in the FIFO
	task automatic s_reset();
		out_ready = 0;
		push(300, 0);
		in_valid = 0;
		chk("parked", 16'(out_valid), 16'h0001);
		sys_rst = 1;
		repeat (3) @(negedge mclk);
		sys_rst = 0;
		out_ready = 1;
		chk("rst_valid", 16'(out_valid), 16'h0000);
		chk("rst_dark", 16'(dark_row_active), 16'h0000);
		chk("rst_rdata", reg_rdata, 16'h0000);
		rd(9'h080, 16'h0000);
		rd(9'h081, 16'h0000);
		rd(9'h0c5, 16'h0001);
	endtask : s_reset
	task automatic s_manual();
		blc_pkg::blc_kernel_s k;
		wr(9'h081, 16'h000e);
		img(50, 57, 1);
		wr(9'h081, 16'h043c);
		img(50, 20, 1);
		wr(9'h081, 16'h03fe);
		img(900, 1023, 0);
		out_ready = 0;
		wr(9'h081, 16'h043c);
		for (int i = 0; i < 32; i++) push(200, 0);
		in_valid = 0;
		chk("in_ready", 16'(in_ready), 16'h0000);
		out_ready = 1;
		wait_q(32);
		for (int i = 0; i < 32; i++) begin
			k = q.pop_front();
			chk("stall_pix", 16'(k.pix[5]), 16'h00aa);
		end
	endtask : s_manual
	initial begin
		sys_rst = 1;
		reg_wr = 0;
		reg_rd = 0;
		reg_addr = '0;
		reg_wdata = '0;
		frame_start = 0;
		rolling_mode = 0;
		line_kernels = '0;
		in_valid = 0;
		in_kernel = '0;
		out_ready = 1;
		repeat (3) @(negedge mclk);
		sys_rst = 0;
		s_regs();
		s_global();
		s_roll();
		s_reset();
		s_manual();
		close_out();
	end
endmodule : tb

// ==== verilog/blc_fifo.sv ====
`timescale 1ns/10ps
module blc_fifo #(
	parameter int unsigned W     = 82,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [PW:0]             cnt;
	} blc_fifo_s;

	blc_fifo_s q;
	blc_fifo_s d;
	logic      push;
	logic      pop;

	assign in_ready = (q.cnt != (PW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];

	always_comb begin
		d = q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + PW'(1);
		end
		if (pop) begin
			d.rp = q.rp + PW'(1);
		end
		// Simultaneous push and pop keeps the count
		if (push && !pop) begin
			d.cnt = q.cnt + (PW+1)'(1);
		end else if (pop && !push) begin
			d.cnt = q.cnt - (PW+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q.wp <= '0;
			q.rp <= '0;
			q.cnt <= '0;
			q.mem <= q.mem;
		end else begin
			q <= d;
		end
	end

endmodule : blc_fifo

// ==== verilog/blc_top.sv ====
//
// Operation
// R1: Generate the programmed dark row count (1..255) at every frame start.
// R2: Global shutter dark rows are 160 kernels long.
// R3: Rolling shutter dark rows match the active window line length.
// R4: With skip set, first dark row is blanked and excluded from calibration.
// R5: Software programs at least two rows when skipping the first.
// R6: Software is advised to enable first row skipping.
// R7: Auto enable computes offset from dark samples, corrects every image pixel.
// R8: Dark sample pixels leave uncorrected, as raw values.
// R9: Auto disabled corrects regular pixels by the manual offset magnitude.
// R10: Manual sign 0 adds, 1 subtracts; ignored during auto calibration.
// R11: Manual offset is identical on all data paths.
// R12: Dark samples are low-pass filtered over two to the depth field samples.
// R13: Per-path shortfall flag when requested samples exceed those available.
// R14: On shortfall software adds rows, lowers depth, or uses manual offset.
// R15: Calibration repeats every frame on that frame's dark rows.
// R16: Each of the eight kernel columns is calibrated separately.
// R17: Pixels go toward a configurable target; negative results clip to zero.
// R18: Shortfall flags update once per frame when dark processing ends.
`timescale 1ns/10ps
module blc_top (
	input  wire logic                            mclk,
	input  wire logic                            sys_rst,
	input  wire logic [blc_pkg::ADDR_W-1:0]      reg_addr,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	input  wire logic [blc_pkg::DATA_W-1:0]      reg_wdata,
	output logic [blc_pkg::DATA_W-1:0]           reg_rdata,
	input  wire logic                            frame_start,
	input  wire logic                            rolling_mode,
	input  wire logic [blc_pkg::LEN_W-1:0]       line_kernels,
	output logic                                 dark_row_active,
	input  wire logic                            in_valid,
	output logic                                 in_ready,
	input  wire blc_pkg::blc_kernel_s            in_kernel,
	output logic                                 out_valid,
	input  wire logic                            out_ready,
	output blc_pkg::blc_kernel_s                 out_kernel,
	output logic [blc_pkg::NPATH-1:0]            shortfall_flags
);
	localparam int unsigned NP = blc_pkg::NPATH;
	localparam int unsigned PW = blc_pkg::PIX_W;
	localparam int unsigned AW = blc_pkg::ACC_W;
	localparam int unsigned KW = $bits(blc_pkg::blc_kernel_s);

	typedef struct packed {
		blc_pkg::blc_state_e               state;
		logic [blc_pkg::DATA_W-1:0]        filter_cfg;
		logic [blc_pkg::DATA_W-1:0]        corr_cfg;
		logic [blc_pkg::DATA_W-1:0]        row_cfg;
		logic [blc_pkg::DATA_W-1:0]        rdata;
		logic [blc_pkg::ROWS_W-1:0]        rows;
		logic                              skip;
		logic [blc_pkg::DEPTH_W-1:0]       depth;
		logic [blc_pkg::LEN_W-1:0]         len;
		logic [blc_pkg::ROWS_W-1:0]        row;
		logic [blc_pkg::LEN_W-1:0]         kcnt;
		logic [7:0]                        samp;
		logic [NP-1:0][AW-1:0]             acc;
		logic [NP-1:0][PW-1:0]             black;
		logic [NP-1:0]                     flags;
		logic                              dark_act;
	} blc_core_s;

	blc_core_s           q;
	blc_core_s           d;
	logic                fifo_ready;
	logic                fire;
	logic                in_blank_row;
	logic [7:0]          need;
	blc_pkg::blc_kernel_s corr;

	// Clip a signed sum into the pixel range
	function automatic logic [PW-1:0] blc_clip(input logic signed [PW+2:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > (PW+3)'(2**PW - 1)) begin
			return '1;
		end else begin
			return v[PW-1:0];
		end
	endfunction : blc_clip

	function automatic logic [7:0] blc_need(input logic [blc_pkg::DEPTH_W-1:0] n);
		return 8'h01 << n;
	endfunction : blc_need

	// Frames mid-calibration hold off input while offsets settle
	assign in_ready = fifo_ready && (q.state != blc_pkg::ST_FIN);
	assign fire = in_valid && in_ready;
	assign in_blank_row = q.skip && (q.row == '0);
	assign need = blc_need(q.depth);
	assign reg_rdata = q.rdata;
	assign dark_row_active = q.dark_act;
	assign shortfall_flags = q.flags;

	// Per-path correction of the incoming kernel
	always_comb begin
		logic signed [PW+2:0] base;
		logic signed [PW+2:0] man;
		base = '0;
		man = '0;
		corr.dark = 1'b0;
		corr.blank = 1'b0;
		corr.pix = in_kernel.pix;
		if (q.state == blc_pkg::ST_DARK) begin
			corr.dark = 1'b1; // R8
			if (in_blank_row) begin
				corr.blank = 1'b1; // R4
				corr.pix = '0;
			end
		end else begin
			man = (PW+3)'(q.corr_cfg[blc_pkg::MOFS_LSB +: blc_pkg::MOFS_W]);
			for (int i = 0; i < NP; i++) begin
				base = (PW+3)'(in_kernel.pix[i]);
				if (q.corr_cfg[blc_pkg::AUTO_BIT]) begin
					// R7 R16 R17
					corr.pix[i] = blc_clip(base - (PW+3)'(q.black[i])
						+ (PW+3)'(q.filter_cfg[blc_pkg::TGT_LSB +: blc_pkg::TGT_W]));
				end else if (q.corr_cfg[blc_pkg::MSIGN_BIT]) begin
					corr.pix[i] = blc_clip(base - man); // R9 R10 R11
				end else begin
					corr.pix[i] = blc_clip(base + man); // R9 R10 R11
				end
			end
		end
	end

	always_comb begin
		d = q;
		if (reg_rd) begin
			case (reg_addr)
				blc_pkg::ADDR_FILTER_CFG: d.rdata = q.filter_cfg;
				blc_pkg::ADDR_CORR_CFG: d.rdata = q.corr_cfg;
				blc_pkg::ADDR_SHORTFALL: d.rdata = blc_pkg::DATA_W'(q.flags); // R13
				blc_pkg::ADDR_ROW_CFG: d.rdata = q.row_cfg;
				default: d.rdata = '0;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				blc_pkg::ADDR_FILTER_CFG: d.filter_cfg = reg_wdata;
				blc_pkg::ADDR_CORR_CFG: d.corr_cfg = reg_wdata;
				blc_pkg::ADDR_ROW_CFG: d.row_cfg = reg_wdata;
				default: d.rdata = d.rdata;
			endcase
		end
		case (q.state)
			blc_pkg::ST_IDLE: begin
				d.state = blc_pkg::ST_IDLE;
			end
			blc_pkg::ST_DARK: begin
				if (fire) begin
					// Filter takes the first 2^depth usable samples per column
					if (!in_blank_row && (q.samp < need)) begin // R4 R12
						for (int i = 0; i < NP; i++) begin
							d.acc[i] = q.acc[i] + AW'(in_kernel.pix[i]); // R16
						end
						d.samp = q.samp + 8'h01;
					end
					if (q.kcnt == q.len - blc_pkg::LEN_W'(1)) begin // R2 R3
						d.kcnt = '0;
						d.row = q.row + blc_pkg::ROWS_W'(1);
						if (q.row == q.rows - blc_pkg::ROWS_W'(1)) begin // R1
							d.state = blc_pkg::ST_FIN;
							d.dark_act = 1'b0;
						end
					end else begin
						d.kcnt = q.kcnt + blc_pkg::LEN_W'(1);
					end
				end
			end
			blc_pkg::ST_FIN: begin
				// Shortfall keeps the previous frame's black level
				for (int i = 0; i < NP; i++) begin
					d.flags[i] = (q.samp < need); // R13 R18
					if (q.samp >= need) begin
						d.black[i] = PW'(q.acc[i] >> q.depth); // R12 R15
					end
				end
				d.state = blc_pkg::ST_IMAGE;
			end
			blc_pkg::ST_IMAGE: begin
				d.state = blc_pkg::ST_IMAGE;
			end
			default: begin
				d.state = blc_pkg::ST_IDLE;
			end
		endcase
		if (frame_start) begin
			// Frame restarts dark generation with fresh settings
			d.rows = q.row_cfg[blc_pkg::ROWS_LSB +: blc_pkg::ROWS_W]; // R1
			d.skip = q.row_cfg[blc_pkg::SKIP_BIT]; // R4
			d.depth = q.filter_cfg[blc_pkg::DEPTH_LSB +: blc_pkg::DEPTH_W];
			d.len = rolling_mode ? line_kernels : blc_pkg::GS_ROW_KERNELS; // R2 R3
			d.row = '0;
			d.kcnt = '0;
			d.samp = '0;
			d.acc = '0; // R15
			if (q.row_cfg[blc_pkg::ROWS_LSB +: blc_pkg::ROWS_W] == '0) begin
				d.state = blc_pkg::ST_FIN;
				d.dark_act = 1'b0;
			end else begin
				d.state = blc_pkg::ST_DARK;
				d.dark_act = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q.state <= blc_pkg::ST_IDLE;
			q.filter_cfg <= blc_pkg::RST_FILTER_CFG;
			q.corr_cfg <= blc_pkg::RST_CORR_CFG;
			q.row_cfg <= blc_pkg::RST_ROW_CFG;
			q.rdata <= '0;
			q.rows <= '0;
			q.skip <= 1'b0;
			q.depth <= '0;
			q.len <= blc_pkg::GS_ROW_KERNELS;
			q.row <= '0;
			q.kcnt <= '0;
			q.samp <= '0;
			q.acc <= '0;
			q.black <= '0;
			q.flags <= '0;
			q.dark_act <= 1'b0;
		end else begin
			q <= d;
		end
	end

	blc_fifo #(
		.W     (KW),
		.DEPTH (blc_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_valid  (in_valid && (q.state != blc_pkg::ST_FIN)),
		.in_ready  (fifo_ready),
		.in_data   (corr),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_kernel)
	);

endmodule : blc_top
